// *** logic/suef_top.sv ***
// event flags, mask, interrupt and apb registers of a uart channel
`timescale 1ns/1ps
`include "suef_defs.svh"

// Function
// - set break-end flag only after one idle bit follows a break
// - set break-received flag once per break, on the first all-zeros character
// - no free buffer: discard character, set no-buffer flag at mid stop bit
// - store again as soon as software supplies an empty buffer
// - set transmit-done flag when last buffer character enters the transmit fifo
// - close receive buffer and set receive-done flag at mid last stop bit
// - event bits 7, 5 and 3 are reserved and never set
module suef_top
    import suef_pkg::*;
#(
    parameter int DATA_W = 8
) (
    // clock and reset
    input  wire logic                ref_clk_i,
    input  wire logic                rst_b_i,
    // apb slave
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [11:0]         paddr_i,
    input  wire logic [31:0]         pwdata_i,
    output logic      [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    // receive side
    input  wire suef_rx_char_t       rx_char_i,
    input  wire logic                rx_idle_bit_i,
    input  wire logic                rx_buf_avail_i,
    output logic                     rx_store_o,
    output logic      [DATA_W-1:0]   rx_store_data_o,
    output logic                     rx_close_o,
    output logic                     rx_discard_o,
    // transmit side
    input  wire suef_tx_wr_t         tx_wr_i,
    // interrupt
    output logic                     irq_o
);

    logic [7:0]  event_q;
    logic [7:0]  event_d;
    logic [7:0]  ev_set;
    logic [7:0]  ev_clr;
    logic [7:0]  mask_q;
    logic [31:0] ctrl_q;
    suef_line_t  line_q;
    logic        discard_q;
    logic        rx_en;
    logic        rx_ok_char;
    logic        rx_brk_char;
    logic        wr_acc;
    logic        rd_setup;
    logic        addr_hit;
    logic [31:0] rd_val;

    // an all-zeros character: data clear and stop bit sampled low
    function automatic logic is_break(input suef_rx_char_t c);
        return c.valid && (c.data == '0) && !c.stop_bit;
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        return (a == `SUEF_OFS_EVENT) || (a == `SUEF_OFS_MASK) ||
               (a == `SUEF_OFS_STATUS) || (a == `SUEF_OFS_CTRL);
    endfunction

    // an apb write access to one register
    function automatic logic wr_hit(input logic acc, input logic [11:0] addr,
                                    input logic [11:0] a);
        return acc && (addr == a);
    endfunction

    assign rx_en       = ctrl_q[`SUEF_CTRL_RX_EN];
    assign rx_brk_char = rx_en && is_break(rx_char_i);
    assign rx_ok_char  = rx_en && rx_char_i.valid && !is_break(rx_char_i);
    assign wr_acc      = psel_i && penable_i && pwrite_i;
    assign rd_setup    = psel_i && !penable_i && !pwrite_i;
    assign addr_hit    = is_mapped(paddr_i);

    // ---------------- break tracking ----------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            line_q <= SUEF_LINE_IDLE;
        end else begin
            unique case (line_q)
                SUEF_LINE_IDLE: begin
                    if (rx_brk_char) begin
                        line_q <= SUEF_LINE_BREAK;
                    end
                end
                SUEF_LINE_BREAK: begin
                    // an idle bit ends the break
                    if (rx_idle_bit_i) begin
                        line_q <= SUEF_LINE_IDLE;
                    end
                end
                default: begin
                    line_q <= SUEF_LINE_IDLE;
                end
            endcase
        end
    end

    // ---------------- receive storage ----------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            rx_store_o      <= 1'b0;
            rx_store_data_o <= '0;
            rx_close_o      <= 1'b0;
            rx_discard_o    <= 1'b0;
        end else begin
            rx_store_o   <= rx_ok_char && rx_buf_avail_i;
            rx_close_o   <= rx_ok_char && rx_buf_avail_i
                            && rx_char_i.last_in_buf;
            rx_discard_o <= rx_ok_char && !rx_buf_avail_i;
            if (rx_ok_char && rx_buf_avail_i) begin
                rx_store_data_o <= rx_char_i.data[DATA_W-1:0];
            end
        end
    end

    // discarding state, left as soon as a buffer is offered
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            discard_q <= 1'b0;
        end else if (rx_buf_avail_i) begin
            discard_q <= 1'b0;
        end else if (rx_ok_char) begin
            discard_q <= 1'b1;
        end
    end

    // ---------------- event flags ----------------
    always_comb begin
        ev_set = '0;
        // break-end only once an idle bit arrives after a break
        ev_set[`SUEF_BIT_BREAK_END_FLAG] = (line_q == SUEF_LINE_BREAK)
                                 && rx_idle_bit_i;
        // only the first all-zeros character of a break flags
        ev_set[`SUEF_BIT_BRK]  = rx_brk_char
                                 && (line_q == SUEF_LINE_IDLE);
        ev_set[`SUEF_BIT_BSY]  = rx_ok_char && !rx_buf_avail_i;
        ev_set[`SUEF_BIT_TXB]  = tx_wr_i.wr
                                 && tx_wr_i.last_in_buf;
        ev_set[`SUEF_BIT_RXB]  = rx_ok_char && rx_buf_avail_i
                                 && rx_char_i.last_in_buf;
    end

    always_comb begin
        ev_clr = '0;
        if (wr_hit(wr_acc, paddr_i, `SUEF_OFS_EVENT)) begin
            ev_clr = pwdata_i[7:0];
        end
    end

    // set wins over a clear in the same cycle; reserved bits stay zero
    assign event_d = ((event_q & ~ev_clr) | ev_set) & `SUEF_EV_IMPL;

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            event_q <= `SUEF_EV_RST;
        end else begin
            event_q <= event_d;
        end
    end

    // ---------------- control registers ----------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            mask_q <= `SUEF_MASK_RST;
        end else if (wr_hit(wr_acc, paddr_i, `SUEF_OFS_MASK)) begin
            mask_q <= pwdata_i[7:0] & `SUEF_EV_IMPL;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            ctrl_q <= `SUEF_CTRL_RST;
        end else if (wr_hit(wr_acc, paddr_i, `SUEF_OFS_CTRL)) begin
            ctrl_q <= pwdata_i & `SUEF_CTRL_RST;
        end
    end

    // ---------------- interrupt ----------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(event_d & mask_q);
        end
    end

    // ---------------- apb read path ----------------
    always_comb begin
        rd_val = '0;
        unique case (paddr_i)
            `SUEF_OFS_EVENT:  rd_val[7:0] = event_q;
            `SUEF_OFS_MASK:   rd_val[7:0] = mask_q;
            `SUEF_OFS_STATUS: begin
                rd_val[`SUEF_ST_IN_BREAK]  = (line_q == SUEF_LINE_BREAK);
                rd_val[`SUEF_ST_DISCARD]   = discard_q;
                rd_val[`SUEF_ST_BUF_AVAIL] = rx_buf_avail_i;
            end
            `SUEF_OFS_CTRL:   rd_val = ctrl_q;
            default:          rd_val = '0;
        endcase
    end

    // read data captured in the setup cycle, valid through the access phase
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            prdata_o <= '0;
        end else if (rd_setup) begin
            prdata_o <= rd_val;
        end
    end

    assign pready_o  = psel_i && penable_i;
    assign pslverr_o = psel_i && penable_i && !addr_hit;

endmodule // suef_top

// *** logic/suef_defs.svh ***
// register offsets, field positions and reset values of the uart event flag block
`ifndef SUEF_DEFS_SVH
`define SUEF_DEFS_SVH

`define SUEF_OFS_EVENT      12'h000
`define SUEF_OFS_MASK       12'h004
`define SUEF_OFS_STATUS     12'h008
`define SUEF_OFS_CTRL       12'h00C

`define SUEF_BIT_RXB        0
`define SUEF_BIT_TXB        1
`define SUEF_BIT_BSY        2
`define SUEF_BIT_BRK        4
`define SUEF_BIT_BREAK_END_FLAG       6

`define SUEF_EV_IMPL        8'h57
`define SUEF_EV_RST         8'h00
`define SUEF_MASK_RST       8'h00
`define SUEF_CTRL_RST       32'h0000_0001

`define SUEF_ST_IN_BREAK    0
`define SUEF_ST_DISCARD     1
`define SUEF_ST_BUF_AVAIL   2
`define SUEF_CTRL_RX_EN     0

`endif

// *** logic/suef_pkg.sv ***
// types shared by the uart event flag block
package suef_pkg;

    // one character from the receive shifter, offered at mid last stop bit
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       stop_bit;
        logic       last_in_buf;
    } suef_rx_char_t;

    // one write into the transmit fifo
    typedef struct packed {
        logic       wr;
        logic       last_in_buf;
    } suef_tx_wr_t;

    typedef enum logic [1:0] {
        SUEF_LINE_IDLE  = 2'b00,
        SUEF_LINE_BREAK = 2'b01
    } suef_line_t;

endpackage

// *** sim/suef_top_sva.sv ***
// concurrent checks on the ports of the uart event flag block
`timescale 1ns/1ps
module suef_top_sva
    import suef_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input wire logic                ref_clk_i, rst_b_i, psel_i, penable_i, pwrite_i,
    input wire logic [11:0]         paddr_i,
    input wire logic [31:0]         pwdata_i, prdata_o,
    input wire logic                pready_o, pslverr_o,
    input wire suef_rx_char_t       rx_char_i,
    input wire logic                rx_idle_bit_i, rx_buf_avail_i, rx_store_o,
    input wire logic [DATA_W-1:0]   rx_store_data_o,
    input wire logic                rx_close_o, rx_discard_o,
    input wire suef_tx_wr_t         tx_wr_i,
    input wire logic                irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    wire acc = psel_i && penable_i;
    wire wr  = acc && pwrite_i;
    wire ev  = rx_char_i.valid || rx_idle_bit_i || tx_wr_i.wr;
    // receiver enable as software last wrote it
    logic en_q;
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) en_q <= 1'b1;
        else if (wr && paddr_i == 12'h00C) en_q <= pwdata_i[0];
    end
    a_rx_off_ignored: assert property (!en_q && rx_char_i.valid
        |=> !rx_store_o && !rx_discard_o) else $error("char taken while off");
    a_ready_zero_wait: assert property (acc |-> pready_o) else $error("pready low");
    a_err_unmapped: assert property (acc && paddr_i > 12'h00C |-> pslverr_o)
        else $error("no slave error");
    a_rsv_bits_zero: assert property (acc && !pwrite_i && paddr_i < 12'h008 |->
        !prdata_o[7] && !prdata_o[5] && !prdata_o[3]) else $error("reserved bit set");
    a_discard_cause: assert property (rx_discard_o |->
        $past(rx_char_i.valid && !rx_buf_avail_i)) else $error("bad discard");
    a_store_data: assert property (rx_store_o |->
        rx_store_data_o == $past(rx_char_i.data)) else $error("bad store data");
    a_resume_store: assert property (en_q && rx_char_i.valid && rx_buf_avail_i && rx_char_i.stop_bit
        |=> rx_store_o && !rx_discard_o) else $error("char not stored");
    a_close_on_last: assert property (rx_close_o |->
        rx_store_o && $past(rx_char_i.last_in_buf)) else $error("bad close");
    a_irq_has_cause: assert property ($rose(irq_o) |->
        $past(ev) || $past(wr) || $past(wr, 2)) else $error("irq without event");
    a_irq_held: assert property ($fell(irq_o) |-> $past(wr) || $past(wr, 2))
        else $error("irq dropped alone");
    c_discard: cover property (rx_discard_o);
    c_close: cover property (rx_close_o);
    c_irq: cover property ($rose(irq_o));
endmodule // suef_top_sva

// *** sim/suef_remote.sv ***
// remote serial station: offers received characters and idle bits
`timescale 1ns/1ps
module suef_remote
    import suef_pkg::*;
(
    input  wire logic    clk_i,
    output suef_rx_char_t ch_o,
    output logic          idle_o
);
    initial begin
        ch_o   = '0;
        idle_o = 1'b0;
    end
    // zero data goes out with a low stop bit, which makes a break
    task automatic send(input logic [7:0] d, input logic last);
        @(posedge clk_i);
        ch_o <= {1'b1, d, |d, last};
        @(posedge clk_i);
        ch_o <= {1'b0, ~d, 1'b1, 1'b0};
    endtask
    task automatic idle_bit();
        @(posedge clk_i);
        idle_o <= 1'b1;
        @(posedge clk_i);
        idle_o <= 1'b0;
    endtask
endmodule // suef_remote

// *** sim/suef_top_bench.sv ***
// self-checking bench of the uart event flag block
`timescale 1ns/1ps
module suef_top_bench;
    import suef_pkg::*;
    logic          clk, rst_b, psel, penable, pwrite, pready, pslverr, err, av, st, cl, ds, irq;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rd;
    logic [7:0]    sd;
    suef_rx_char_t ch;
    suef_tx_wr_t   tx;
    logic          idle;
    int            bad_count, n_checks, cyc;
    suef_top u_suef_top (.ref_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .rx_char_i(ch), .rx_idle_bit_i(idle),
        .rx_buf_avail_i(av), .rx_store_o(st), .rx_store_data_o(sd), .rx_close_o(cl),
        .rx_discard_o(ds), .tx_wr_i(tx), .irq_o(irq));
    suef_remote u_suef_remote (.clk_i(clk), .ch_o(ch), .idle_o(idle));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // setup cycle, then access until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, tx, rst_b} = '0;
        av = 1'b1;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        rdchk(12'h000, 32'h0, "event");
        rdchk(12'h00C, 32'h1, "ctrl");
        apb(1'b1, 12'h004, 32'hFF);
        rdchk(12'h004, 32'h57, "mask");
        u_suef_remote.send(8'hA5, 1'b1);
        rdchk(12'h000, 32'h1, "rx done");
        chk("irq", irq, 1);
        apb(1'b1, 12'h000, 32'hFE);
        rdchk(12'h000, 32'h1, "w0 keeps");
        apb(1'b1, 12'h000, 32'h1);
        rdchk(12'h000, 32'h0, "w1 clears");
        chk("irq off", irq, 0);
        $display("rx done test end");
        av <= 1'b0;
        u_suef_remote.send(8'h3C, 1'b1);
        rdchk(12'h000, 32'h4, "discard");
        chk("dropped", sd, 8'hA5);
        rdchk(12'h008, 32'h2, "discarding");
        av <= 1'b1;
        u_suef_remote.send(8'h5A, 1'b0);
        rdchk(12'h000, 32'h4, "no close");
        chk("resumed", sd, 8'h5A);
        rdchk(12'h008, 32'h4, "buffer back");
        apb(1'b1, 12'h000, 32'h4);
        $display("discard test end");
        u_suef_remote.idle_bit();
        rdchk(12'h000, 32'h0, "idle only");
        u_suef_remote.send(8'h00, 1'b0);
        rdchk(12'h000, 32'h10, "break");
        apb(1'b1, 12'h000, 32'h10);
        u_suef_remote.send(8'h00, 1'b0);
        rdchk(12'h000, 32'h0, "break once");
        u_suef_remote.idle_bit();
        rdchk(12'h000, 32'h40, "break end");
        apb(1'b1, 12'h000, 32'h40);
        apb(1'b1, 12'h00C, 32'h0);
        u_suef_remote.send(8'h11, 1'b1);
        rdchk(12'h000, 32'h0, "rx off");
        chk("not stored", sd, 8'h5A);
        apb(1'b1, 12'h00C, 32'h1);
        rdchk(12'h00C, 32'h1, "rx on");
        $display("break test end");
        apb(1'b1, 12'h004, 32'h0);
        tx <= 2'b10;
        @(posedge clk) tx <= 2'b00;
        rdchk(12'h000, 32'h0, "tx mid");
        tx <= 2'b11;
        @(posedge clk) tx <= 2'b00;
        rdchk(12'h000, 32'h2, "tx done");
        chk("masked", irq, 0);
        // software lets two character times pass before the line counts as empty
        repeat (4) @(posedge clk);
        rdchk(12'h000, 32'h2, "tx still set");
        apb(1'b1, 12'h004, 32'h2);
        rdchk(12'h010, 32'h0, "unmapped");
        chk("slverr", err, 1);
        chk("unmasked", irq, 1);
        $display("tx test end");
        report_and_stop();
    end
endmodule // suef_top_bench
bind suef_top suef_top_sva #(.DATA_W(DATA_W)) u_suef_top_sva (.*);
